// ### logic/cscpa_pkg.sv
`default_nettype none
package cscpa_pkg;
  // Module and map sizing
  localparam logic [5:0] MOD_WORDS_MIN    = 6'h01;
  localparam logic [5:0] MOD_WORDS_MAX    = 6'h20;
  localparam logic [7:0] EXCESS_BYTES_MAX = 8'h20;   // Allowed module excess over the maps
  localparam logic [4:0] MAP_ENTRIES      = 5'h10;   // Entries per parameter map
  localparam logic [4:0] PLC_WORDS_MAX    = 5'h10;   // Extra words for the embedded PLC application
  localparam logic [7:0] BYTES_SHORT      = 8'h02;
  localparam logic [7:0] BYTES_LONG       = 8'h04;
  localparam logic [7:0] BYTES_BYTE       = 8'h01;
  // Fault subcodes
  localparam logic [15:0] SUB_OUT_MISMATCH = 16'h0084;
  localparam logic [15:0] SUB_IN_MISMATCH  = 16'h0074;
  // Diagnostic code offset
  localparam logic [15:0] DIAG_OFFSET      = 16'h00FF;
  localparam logic [7:0]  ALARM_MAX        = 8'h3C;
  localparam logic [15:0] PAR_INDEX_MAX    = 16'hFFFF;

  // Parameter data types
  typedef enum logic [3:0] {
    CS_T_BIT    = 4'h0,
    CS_T_ENUM   = 4'h1,
    CS_T_FLOAT  = 4'h2,
    CS_T_INMAP  = 4'h3,
    CS_T_OUTMAP = 4'h4,
    CS_T_INT16  = 4'h5,
    CS_T_INT32  = 4'h6,
    CS_T_ILINK  = 4'h7,
    CS_T_LINK   = 4'h8,
    CS_T_UINT16 = 4'h9,
    CS_T_UINT32 = 4'hA,
    CS_T_SINT   = 4'hB
  } cs_type_e;

  // Fieldbus state, one-hot
  typedef enum logic [2:0] {
    CS_IDLE   = 3'b001,
    CS_PREOP  = 3'b010,
    CS_OPER   = 3'b100
  } cs_state_e;

  // Record request state, one-hot
  typedef enum logic [2:0] {
    CS_RQ_IDLE = 3'b001,
    CS_RQ_WAIT = 3'b010,
    CS_RQ_DONE = 3'b100
  } cs_rq_e;
endpackage
`default_nettype wire

// ### logic/cscpa_len.sv
`timescale 1ns/100ps
`default_nettype none
// Transfer length in bytes for one parameter data type
module cscpa_len
  import cscpa_pkg::*;
(
  input  wire logic [3:0] dtype,
  output logic      [7:0] nbytes
);
  // Length lookup by data type
  always_comb begin
    case (dtype)
      CS_T_FLOAT, CS_T_INT32, CS_T_UINT32: nbytes = BYTES_LONG;
      CS_T_SINT:                           nbytes = BYTES_BYTE;
      default:                             nbytes = BYTES_SHORT;
    endcase
  end
endmodule
`default_nettype wire

// ### logic/cscpa_top.sv
// Overview of operation
// - Master modules range from one to thirty-two words.
// - Module smaller than the larger map size is a mismatch.
// - Module larger than map size by over 32 bytes is a mismatch.
// - Input and output maps may differ; compare against the larger.
// - Up to 16 leftover words go to the embedded PLC application.
// - Mismatch blocks cyclic exchange and reports pre-operational state.
// - Mismatch raises bus fault, subcode 0084h output, 0074h input.
// - Allowed size is adopted; save keeps it; after restart, connecting that size gives operational.
// - Disallowed saved size never auto-operates; both subcodes after restart if the last connected size was disallowed.
// - Forced same module or cable reconnect still enters operational.
// - Record write changes writable parameters; record read returns parameters.
// - Record index equals the addressed parameter index.
// - Lengths: 2 for 16-bit kinds, 4 for 32-bit and float, 1 for byte.
// - Map index entries accept only nonzero parameter numbers.
// - Diagnostic code equals alarm code plus 255, 256 to 315.
// - Each map needs one entry or no module can match.
// - Each mapped parameter counts as 2 or 4 bytes.
`timescale 1ns/100ps
`default_nettype none
module cscpa_top
  import cscpa_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RESETN,
  input  wire logic        MOD_CONNECT,
  input  wire logic        MOD_FORCE,
  input  wire logic [5:0]  MOD_WORDS,
  input  wire logic [15:0] IN_MAP_LONG,
  input  wire logic [15:0] IN_MAP_USED,
  input  wire logic [15:0] OUT_MAP_LONG,
  input  wire logic [15:0] OUT_MAP_USED,
  input  wire logic        SAVE_CMD,
  input  wire logic        RESTART,
  input  wire logic        REC_REQ,
  input  wire logic        REC_WRITE,
  input  wire logic [15:0] REC_INDEX,
  input  wire logic [7:0]  REC_LEN,
  input  wire logic [31:0] REC_WDATA,
  input  wire logic        PAR_ACK,
  input  wire logic        PAR_EXISTS,
  input  wire logic        PAR_WRITABLE,
  input  wire logic [3:0]  PAR_TYPE,
  input  wire logic [31:0] PAR_RDATA,
  input  wire logic [7:0]  ALARM_CODE,
  input  wire logic        ALARM_VALID,
  output logic             PAR_REQ,
  output logic             PAR_WE,
  output logic [15:0]      PAR_INDEX,
  output logic [31:0]      PAR_WDATA,
  output logic             REC_DONE,
  output logic             REC_ERR,
  output logic [31:0]      REC_RDATA,
  output logic [7:0]       REC_RLEN,
  output logic             CYCLIC_EN,
  output logic             STATE_PREOP,
  output logic             STATE_OPER,
  output logic             BUS_FAULT,
  output logic [15:0]      FAULT_SUB_OUT,
  output logic [15:0]      FAULT_SUB_IN,
  output logic [4:0]       PLC_IN_WORDS,
  output logic [4:0]       PLC_OUT_WORDS,
  output logic [15:0]      DIAG_CODE,
  output logic             DIAG_VALID,
  output logic [5:0]       SAVED_WORDS
);
  // Map byte counts: 2 or 4 bytes per used entry
  logic [7:0] in_bytes;
  logic [7:0] out_bytes;
  logic [7:0] max_bytes;
  logic [7:0] mod_bytes;
  always_comb begin
    in_bytes  = 8'h00;
    out_bytes = 8'h00;
    for (int i = 0; i < MAP_ENTRIES; i++) begin
      if (IN_MAP_USED[i]) begin
        in_bytes = in_bytes + (IN_MAP_LONG[i] ? BYTES_LONG : BYTES_SHORT);
      end
      if (OUT_MAP_USED[i]) begin
        out_bytes = out_bytes + (OUT_MAP_LONG[i] ? BYTES_LONG : BYTES_SHORT);
      end
    end
  end
  assign max_bytes = (in_bytes > out_bytes) ? in_bytes : out_bytes;
  assign mod_bytes = {1'b0, MOD_WORDS, 1'b0};
  // Size check: module in range, not below, not above by over 32 bytes
  logic mod_legal;
  logic size_ok;
  logic in_ok;
  logic out_ok;
  assign mod_legal = (MOD_WORDS >= MOD_WORDS_MIN) && (MOD_WORDS <= MOD_WORDS_MAX);
  // An empty map can never match, so a zero size fails here
  assign in_ok  = (in_bytes != 8'h00) && (mod_bytes >= in_bytes);
  assign out_ok = (out_bytes != 8'h00) && (mod_bytes >= out_bytes);
  assign size_ok = mod_legal && in_ok && out_ok && (mod_bytes >= max_bytes)
                   && ((mod_bytes - max_bytes) <= EXCESS_BYTES_MAX);
  // Fieldbus state machine
  cs_state_e  state_ff, nxt_state;
  logic [5:0] saved_ff, nxt_saved;
  logic [5:0] cfg_ff, nxt_cfg;
  logic [5:0] last_mod_ff, nxt_last_mod;
  logic       sub_out_ff, nxt_sub_out;
  logic       sub_in_ff, nxt_sub_in;
  logic       cfg_bad_ff, nxt_cfg_bad;
  always_comb begin
    nxt_state    = state_ff;
    nxt_saved    = saved_ff;
    nxt_cfg      = cfg_ff;
    nxt_last_mod = last_mod_ff;
    nxt_sub_out  = sub_out_ff;
    nxt_sub_in   = sub_in_ff;
    nxt_cfg_bad  = cfg_bad_ff;
    if (SAVE_CMD) begin
      nxt_saved = cfg_ff;
    end
    if (RESTART) begin
      // Restart reloads the saved size; both subcodes follow the bad flag of the last connected size
      nxt_state = CS_IDLE;
      nxt_cfg   = saved_ff;
      if (cfg_bad_ff) begin
        nxt_sub_out = 1'b1;
        nxt_sub_in  = 1'b1;
      end else begin
        nxt_sub_out = 1'b0;
        nxt_sub_in  = 1'b0;
      end
    end else if (MOD_CONNECT) begin
      nxt_last_mod = MOD_WORDS;
      case (state_ff)
        CS_IDLE, CS_PREOP, CS_OPER: begin
          if (size_ok) begin
            nxt_cfg     = MOD_WORDS;
            nxt_cfg_bad = 1'b0;
            nxt_sub_out = 1'b0;
            nxt_sub_in  = 1'b0;
            // New size is adopted at once; operational only on a reconnect of the same size
            nxt_state   = (MOD_WORDS == cfg_ff) ? CS_OPER : CS_PREOP;
          end else if ((cfg_bad_ff || sub_out_ff || sub_in_ff) && MOD_FORCE
                       && (MOD_WORDS == last_mod_ff)) begin
            // Forced reconnect of the same module still runs, data invalid
            nxt_state = CS_OPER;
          end else begin
            nxt_state   = CS_PREOP;
            nxt_cfg     = MOD_WORDS;
            nxt_cfg_bad = 1'b1;
            nxt_sub_out = !(mod_legal && out_ok && ((mod_bytes - out_bytes) <= EXCESS_BYTES_MAX));
            nxt_sub_in  = !(mod_legal && in_ok && ((mod_bytes - in_bytes) <= EXCESS_BYTES_MAX));
          end
        end
        default: nxt_state = CS_IDLE;
      endcase
    end
  end
  // State registers
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_ff    <= CS_IDLE;
      saved_ff    <= 6'h00;
      cfg_ff      <= 6'h00;
      last_mod_ff <= 6'h00;
      sub_out_ff  <= 1'b0;
      sub_in_ff   <= 1'b0;
      cfg_bad_ff  <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      saved_ff    <= nxt_saved;
      cfg_ff      <= nxt_cfg;
      last_mod_ff <= nxt_last_mod;
      sub_out_ff  <= nxt_sub_out;
      sub_in_ff   <= nxt_sub_in;
      cfg_bad_ff  <= nxt_cfg_bad;
    end
  end
  // State outputs; cyclic data only in operational state
  assign CYCLIC_EN     = (state_ff == CS_OPER);
  assign STATE_PREOP   = (state_ff == CS_PREOP);
  assign STATE_OPER    = (state_ff == CS_OPER);
  assign BUS_FAULT     = sub_out_ff | sub_in_ff;
  assign FAULT_SUB_OUT = sub_out_ff ? SUB_OUT_MISMATCH : 16'h0000;
  assign FAULT_SUB_IN  = sub_in_ff ? SUB_IN_MISMATCH : 16'h0000;
  assign SAVED_WORDS   = saved_ff;
  // Leftover words for the embedded PLC application, capped at 16
  logic [5:0] in_words;
  logic [5:0] out_words;
  logic [5:0] left_in;
  logic [5:0] left_out;
  assign in_words  = in_bytes[6:1] + {5'h00, in_bytes[0]};
  assign out_words = out_bytes[6:1] + {5'h00, out_bytes[0]};
  assign left_in   = (cfg_ff > in_words) ? (cfg_ff - in_words) : 6'h00;
  assign left_out  = (cfg_ff > out_words) ? (cfg_ff - out_words) : 6'h00;
  assign PLC_IN_WORDS  = (left_in > {1'b0, PLC_WORDS_MAX}) ? PLC_WORDS_MAX : left_in[4:0];
  assign PLC_OUT_WORDS = (left_out > {1'b0, PLC_WORDS_MAX}) ? PLC_WORDS_MAX : left_out[4:0];
  // Record access length from parameter type
  logic [7:0] type_len;
  cscpa_len u_len (
    .dtype  (PAR_TYPE),
    .nbytes (type_len)
  );
  // Record request machine
  cs_rq_e      rq_ff, nxt_rq;
  logic        we_ff, nxt_we;
  logic [15:0] idx_ff, nxt_idx;
  logic [31:0] wdat_ff, nxt_wdat;
  logic [7:0]  len_ff, nxt_len;
  logic [31:0] rdat_ff, nxt_rdat;
  logic [7:0]  rlen_ff, nxt_rlen;
  logic        err_ff, nxt_err;
  logic        bad_map;
  // Map index entries must be nonzero; existence is checked only for the addressed entry
  assign bad_map = ((PAR_TYPE == CS_T_INMAP) || (PAR_TYPE == CS_T_OUTMAP))
                   && (wdat_ff[15:0] == 16'h0000 || !PAR_EXISTS);
  always_comb begin
    nxt_rq   = rq_ff;
    nxt_we   = we_ff;
    nxt_idx  = idx_ff;
    nxt_wdat = wdat_ff;
    nxt_len  = len_ff;
    nxt_rdat = rdat_ff;
    nxt_rlen = rlen_ff;
    nxt_err  = err_ff;
    case (rq_ff)
      CS_RQ_IDLE: begin
        if (REC_REQ) begin
          nxt_rq   = CS_RQ_WAIT;
          nxt_we   = REC_WRITE;
          nxt_idx  = REC_INDEX;
          nxt_wdat = REC_WDATA;
          nxt_len  = REC_LEN;
        end
      end
      CS_RQ_WAIT: begin
        if (PAR_ACK) begin
          nxt_rq   = CS_RQ_DONE;
          nxt_rlen = type_len;
          nxt_rdat = we_ff ? 32'h0000_0000 : PAR_RDATA;
          nxt_err  = !PAR_EXISTS || (len_ff != type_len)
                     || (we_ff && (!PAR_WRITABLE || bad_map));
        end
      end
      CS_RQ_DONE: nxt_rq = CS_RQ_IDLE;
      default:    nxt_rq = CS_RQ_IDLE;
    endcase
  end
  // Request registers
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rq_ff   <= CS_RQ_IDLE;
      we_ff   <= 1'b0;
      idx_ff  <= 16'h0000;
      wdat_ff <= 32'h0000_0000;
      len_ff  <= 8'h00;
      rdat_ff <= 32'h0000_0000;
      rlen_ff <= 8'h00;
      err_ff  <= 1'b0;
    end else begin
      rq_ff   <= nxt_rq;
      we_ff   <= nxt_we;
      idx_ff  <= nxt_idx;
      wdat_ff <= nxt_wdat;
      len_ff  <= nxt_len;
      rdat_ff <= nxt_rdat;
      rlen_ff <= nxt_rlen;
      err_ff  <= nxt_err;
    end
  end
  // Parameter port is held while waiting; the write strobe is gated at ack
  assign PAR_REQ   = (rq_ff == CS_RQ_WAIT);
  assign PAR_INDEX = idx_ff;
  assign PAR_WDATA = wdat_ff;
  assign PAR_WE    = (rq_ff == CS_RQ_WAIT) && we_ff && PAR_ACK && PAR_EXISTS
                     && PAR_WRITABLE && !bad_map && (len_ff == type_len);
  assign REC_DONE  = (rq_ff == CS_RQ_DONE);
  assign REC_ERR   = err_ff;
  assign REC_RDATA = rdat_ff;
  assign REC_RLEN  = rlen_ff;
  // Alarm to diagnostic code, codes outside 1..60 ignored
  logic [15:0] diag_ff, nxt_diag;
  logic        dval_ff, nxt_dval;
  always_comb begin
    nxt_diag = diag_ff;
    nxt_dval = 1'b0;
    if (ALARM_VALID && (ALARM_CODE != 8'h00) && (ALARM_CODE <= ALARM_MAX)) begin
      nxt_diag = {8'h00, ALARM_CODE} + DIAG_OFFSET;
      nxt_dval = 1'b1;
    end
  end
  // Diagnostic registers
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      diag_ff <= 16'h0000;
      dval_ff <= 1'b0;
    end else begin
      diag_ff <= nxt_diag;
      dval_ff <= nxt_dval;
    end
  end
  assign DIAG_CODE  = diag_ff;
  assign DIAG_VALID = dval_ff;
  // Checks
  a_mismatch_preop: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    MOD_CONNECT && !RESTART && !size_ok && !MOD_FORCE |=> STATE_PREOP && !CYCLIC_EN)
    else $error("mismatch did not give preop");
  a_fault_subcode: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    BUS_FAULT |-> (FAULT_SUB_OUT == SUB_OUT_MISMATCH || FAULT_SUB_IN == SUB_IN_MISMATCH))
    else $error("fault without subcode");
  a_excess_limit: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    size_ok |-> (mod_bytes <= max_bytes + EXCESS_BYTES_MAX))
    else $error("excess over limit accepted");
  a_min_size: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    size_ok |-> (mod_bytes >= in_bytes && mod_bytes >= out_bytes))
    else $error("small module accepted");
  a_empty_map: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (IN_MAP_USED == 16'h0000 || OUT_MAP_USED == 16'h0000) |-> !size_ok)
    else $error("empty map matched");
  a_restart_bad: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    RESTART && cfg_bad_ff |=> FAULT_SUB_OUT == SUB_OUT_MISMATCH && FAULT_SUB_IN == SUB_IN_MISMATCH && !CYCLIC_EN)
    else $error("bad saved size not reported");
  a_save_keeps: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    SAVE_CMD && !RESTART |=> SAVED_WORDS == $past(cfg_ff))
    else $error("save lost size");
  a_diag_code: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    ALARM_VALID && ALARM_CODE == 8'h01 |=> DIAG_VALID && DIAG_CODE == 16'h0100)
    else $error("diag code wrong");
  a_rec_answer: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    PAR_REQ && PAR_ACK |=> REC_DONE ##1 !REC_DONE)
    else $error("record answer timing");
  a_plc_cap: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    PLC_IN_WORDS <= PLC_WORDS_MAX && PLC_OUT_WORDS <= PLC_WORDS_MAX)
    else $error("plc words over cap");
  c_oper: cover property (@(posedge SYS_CLK) disable iff (!RESETN) STATE_OPER);
  c_preop: cover property (@(posedge SYS_CLK) disable iff (!RESETN) STATE_PREOP && BUS_FAULT);
  c_write: cover property (@(posedge SYS_CLK) disable iff (!RESETN) PAR_WE);
  c_diag: cover property (@(posedge SYS_CLK) disable iff (!RESETN) DIAG_VALID);
endmodule
`default_nettype wire

// ### tb/cscpa_par_model.sv
`timescale 1ns/100ps
`default_nettype none
// Drive parameter store on the far side of the parameter request port
module cscpa_par_model
  import cscpa_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [3:0]  lat,
  input  wire logic        par_req,
  input  wire logic        par_we,
  input  wire logic [15:0] par_index,
  input  wire logic [31:0] par_wdata,
  output logic             par_ack,
  output logic             par_exists,
  output logic             par_writable,
  output logic [3:0]       par_type,
  output logic [31:0]      par_rdata
);
  logic [3:0]  wait_ff;
  logic [15:0] wr_idx_ff;
  logic [31:0] wr_dat_ff;
  logic [3:0]  kind;

  // Type follows the low index nibble; spare codes fall back to a 16-bit integer
  assign kind = (par_index[3:0] > 4'hb) ? CS_T_INT16 : par_index[3:0];

  // Answer after lat cycles; between answers the qualifiers toggle so stale values never pass
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wait_ff      <= 4'h0;
      wr_idx_ff    <= 16'hffff;
      wr_dat_ff    <= 32'h0000_0000;
      par_ack      <= 1'b0;
      par_exists   <= 1'b0;
      par_writable <= 1'b0;
      par_type     <= 4'hf;
      par_rdata    <= 32'h0000_0000;
    end else begin
      par_ack      <= 1'b0;
      par_exists   <= ~par_exists;
      par_writable <= ~par_writable;
      par_type     <= ~par_type;
      par_rdata    <= ~par_rdata;
      wait_ff      <= 4'h0;
      if (par_req && !par_ack) begin
        wait_ff <= wait_ff + 4'h1;
        if (wait_ff == lat) begin
          wait_ff      <= 4'h0;
          par_ack      <= 1'b1;
          par_exists   <= (par_index < 16'h4000);
          par_writable <= !par_index[8];
          par_type     <= kind;
          par_rdata    <= (par_index == wr_idx_ff) ? wr_dat_ff : {~par_index, par_index};
        end
      end
      // A write lands only when the block qualifies it during the answer
      if (par_ack && par_we) begin
        wr_idx_ff <= par_index;
        wr_dat_ff <= par_wdata;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/cyclic_size_check_param_access_tb.sv
`timescale 1ns/100ps
`default_nettype none
module cyclic_size_check_param_access_tb
  import cscpa_pkg::*;
;
  typedef struct packed {
    logic [5:0] words; logic [15:0] iu; logic [15:0] il; logic [15:0] ou; logic [15:0] ol;
    logic ok; logic so; logic si; logic [4:0] pi; logic [4:0] po;
  } cscpa_szrow_s;
  logic sys_clk = 1'b0;
  logic resetn, mod_connect, mod_force, save_cmd, restart, rec_req, rec_write, alarm_valid;
  logic [5:0] mod_words, saved_words;
  logic [15:0] in_map_long, in_map_used, out_map_long, out_map_used, rec_index, par_index;
  logic [15:0] fault_sub_out, fault_sub_in, diag_code, wr_idx;
  logic [7:0] rec_len, alarm_code, rec_rlen;
  logic [31:0] rec_wdata, par_rdata, par_wdata, rec_rdata, wr_dat;
  logic [3:0] par_type, lat;
  logic par_ack, par_exists, par_writable, par_req, par_we, rec_done, rec_err;
  logic cyclic_en, state_preop, state_oper, bus_fault, diag_valid, v, ok;
  logic [4:0] plc_in_words, plc_out_words;
  logic [15:0] dc;
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int n;
  cscpa_szrow_s r;
  // Maps given as used/long masks; expected results worked out by hand per row
  cscpa_szrow_s szrows [11] = '{
    '{6'h08, 16'h00ff, 16'h0000, 16'h003f, 16'h0000, 1'b1, 1'b0, 1'b0, 5'h00, 5'h02},
    '{6'h18, 16'h00ff, 16'h0000, 16'h003f, 16'h0000, 1'b1, 1'b0, 1'b0, 5'h10, 5'h10},
    '{6'h0a, 16'h00ff, 16'h0000, 16'h003f, 16'h0000, 1'b1, 1'b0, 1'b0, 5'h02, 5'h04},
    '{6'h06, 16'h00ff, 16'h0000, 16'h000f, 16'h0000, 1'b0, 1'b0, 1'b1, 5'h00, 5'h00},
    '{6'h20, 16'h00ff, 16'h0000, 16'h003f, 16'h0000, 1'b0, 1'b1, 1'b1, 5'h00, 5'h00},
    '{6'h19, 16'h00ff, 16'h0000, 16'h003f, 16'h0000, 1'b0, 1'b1, 1'b1, 5'h00, 5'h00},
    '{6'h08, 16'h000f, 16'h000f, 16'h000f, 16'h0003, 1'b1, 1'b0, 1'b0, 5'h00, 5'h02},
    '{6'h01, 16'h0001, 16'h0000, 16'h0001, 16'h0000, 1'b1, 1'b0, 1'b0, 5'h00, 5'h00},
    '{6'h01, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 1'b0, 1'b1, 1'b1, 5'h00, 5'h00},
    '{6'h20, 16'hffff, 16'h0000, 16'hffff, 16'h0000, 1'b1, 1'b0, 1'b0, 5'h10, 5'h10},
    '{6'h21, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 1'b0, 1'b1, 1'b1, 5'h00, 5'h00}};
  logic [7:0] acodes [4] = '{8'h01, 8'h3c, 8'h00, 8'h3d};

  cscpa_top i_cscpa_top (.SYS_CLK(sys_clk), .RESETN(resetn), .MOD_CONNECT(mod_connect), .MOD_FORCE(mod_force),
    .MOD_WORDS(mod_words), .IN_MAP_LONG(in_map_long), .IN_MAP_USED(in_map_used), .OUT_MAP_LONG(out_map_long),
    .OUT_MAP_USED(out_map_used), .SAVE_CMD(save_cmd), .RESTART(restart), .REC_REQ(rec_req),
    .REC_WRITE(rec_write), .REC_INDEX(rec_index), .REC_LEN(rec_len), .REC_WDATA(rec_wdata),
    .PAR_ACK(par_ack), .PAR_EXISTS(par_exists), .PAR_WRITABLE(par_writable), .PAR_TYPE(par_type),
    .PAR_RDATA(par_rdata), .ALARM_CODE(alarm_code), .ALARM_VALID(alarm_valid), .PAR_REQ(par_req),
    .PAR_WE(par_we), .PAR_INDEX(par_index), .PAR_WDATA(par_wdata), .REC_DONE(rec_done), .REC_ERR(rec_err),
    .REC_RDATA(rec_rdata), .REC_RLEN(rec_rlen), .CYCLIC_EN(cyclic_en), .STATE_PREOP(state_preop),
    .STATE_OPER(state_oper), .BUS_FAULT(bus_fault), .FAULT_SUB_OUT(fault_sub_out), .FAULT_SUB_IN(fault_sub_in),
    .PLC_IN_WORDS(plc_in_words), .PLC_OUT_WORDS(plc_out_words), .DIAG_CODE(diag_code),
    .DIAG_VALID(diag_valid), .SAVED_WORDS(saved_words));

  cscpa_par_model i_cscpa_par_model (.sys_clk(sys_clk), .resetn(resetn), .lat(lat), .par_req(par_req),
    .par_we(par_we), .par_index(par_index), .par_wdata(par_wdata), .par_ack(par_ack), .par_exists(par_exists),
    .par_writable(par_writable), .par_type(par_type), .par_rdata(par_rdata));

  always #2 sys_clk = ~sys_clk;

  // Hang guard; the whole run needs well under 2000 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 6000) begin
      err_count++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Byte length a type should carry on the record interface
  function automatic logic [7:0] tlen(input logic [3:0] t);
    case (t)
      CS_T_FLOAT, CS_T_INT32, CS_T_UINT32: tlen = 8'h04;
      CS_T_SINT: tlen = 8'h01;
      default: tlen = 8'h02;
    endcase
  endfunction

  function automatic logic [31:0] exp_rd(input logic [15:0] idx);
    exp_rd = (idx == wr_idx) ? wr_dat : {~idx, idx};
  endfunction

  task automatic maps(input logic [15:0] iu, il, ou, ol);
    @(negedge sys_clk);
    in_map_used = iu;
    in_map_long = il;
    out_map_used = ou;
    out_map_long = ol;
  endtask

  // Connect pulse; the state is looked at once the answer cycle has settled
  task automatic conn(input logic [5:0] w, input logic f);
    @(negedge sys_clk);
    mod_words = w;
    mod_connect = 1'b1;
    mod_force = f;
    @(negedge sys_clk);
    mod_connect = 1'b0;
    mod_force = 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic pulse(input logic rst);
    @(negedge sys_clk);
    save_cmd = !rst;
    restart = rst;
    @(negedge sys_clk);
    save_cmd = 1'b0;
    restart = 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic rec(input logic w, input logic [15:0] idx, input logic [7:0] len, input logic [31:0] wd,
                     input logic e);
    logic we_seen;
    logic [15:0] ix;
    logic [31:0] m;
    logic [7:0] tl;
    we_seen = 1'b0;
    ix = 16'h0000;
    tl = tlen((idx[3:0] > 4'hb) ? CS_T_INT16 : idx[3:0]);
    m = (tl == 8'h01) ? 32'h0000_00ff : (tl == 8'h02) ? 32'h0000_ffff : 32'hffff_ffff;
    @(negedge sys_clk);
    rec_req = 1'b1;
    rec_write = w;
    rec_index = idx;
    rec_len = len;
    rec_wdata = wd;
    @(negedge sys_clk);
    rec_req = 1'b0;
    repeat (40) begin
      if (par_req === 1'b1) ix = par_index;
      if (par_we === 1'b1) we_seen = 1'b1;
      if (rec_done === 1'b1) break;
      @(negedge sys_clk);
    end
    chk("rec_done", rec_done, 1'b1);
    chk("par_index", ix, idx);
    chk("rec_err", rec_err, e);
    chk("par_we", we_seen, w & !e);
    if (!e) begin
      chk("rec_rlen", rec_rlen, tl);
      if (!w) chk("rec_rdata", rec_rdata & m, exp_rd(idx) & m);
      if (w) wr_idx = idx;
      if (w) wr_dat = wd;
    end
  endtask

  initial begin
    {resetn, mod_connect, mod_force, save_cmd, restart, rec_req, rec_write, alarm_valid} = 8'h00;
    {mod_words, rec_len, alarm_code, lat} = 26'h000_0000;
    {in_map_long, in_map_used, out_map_long, out_map_used, rec_index} = 80'h0;
    rec_wdata = 32'h0000_0000;
    wr_idx = 16'hffff;
    wr_dat = 32'h0000_0000;
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    resetn = 1'b1;
    // Size check table: second connect of the same size shows the settled state
    foreach (szrows[i]) begin
      r = szrows[i];
      maps(r.iu, r.il, r.ou, r.ol);
      conn(r.words, 1'b0);
      conn(r.words, 1'b0);
      chk("state_oper", state_oper, r.ok);
      chk("cyclic_en", cyclic_en, r.ok);
      chk("state_preop", state_preop, !r.ok);
      chk("bus_fault", bus_fault, !r.ok);
      chk("sub_out", fault_sub_out, r.so ? SUB_OUT_MISMATCH : 16'h0000);
      chk("sub_in", fault_sub_in, r.si ? SUB_IN_MISMATCH : 16'h0000);
      if (r.ok) chk("plc_in", plc_in_words, r.pi);
      if (r.ok) chk("plc_out", plc_out_words, r.po);
    end
    // Saved size comes back at restart even after an unsaved change
    maps(16'h00ff, 16'h0000, 16'h003f, 16'h0000);
    conn(6'h08, 1'b0);
    pulse(1'b0);
    chk("saved_words", saved_words, 6'h08);
    conn(6'h0a, 1'b0);
    pulse(1'b1);
    conn(6'h08, 1'b0);
    chk("oper_after_restart", state_oper, 1'b1);
    // Disallowed module survives a save and restart only as a fault, until forced
    conn(6'h20, 1'b0);
    pulse(1'b0);
    pulse(1'b1);
    chk("restart_sub_out", fault_sub_out, SUB_OUT_MISMATCH);
    chk("restart_sub_in", fault_sub_in, SUB_IN_MISMATCH);
    chk("restart_oper", state_oper, 1'b0);
    conn(6'h20, 1'b1);
    chk("forced_oper", state_oper, 1'b1);
    // Every type read with its own length, answers after latency 0, 1 and 2 in turn
    for (int t = 0; t < 12; t++) begin
      lat = 4'(t % 3);
      rec(1'b0, {12'h010, 4'(t)}, tlen(4'(t)), 32'h0000_0000, 1'b0);
    end
    rec(1'b1, 16'h0025, 8'h02, 32'h0000_1234, 1'b0);
    rec(1'b0, 16'h0025, 8'h02, 32'h0000_0000, 1'b0);
    rec(1'b1, 16'h0105, 8'h02, 32'h0000_5555, 1'b1);
    rec(1'b0, 16'h4005, 8'h02, 32'h0000_0000, 1'b1);
    rec(1'b0, 16'h0022, 8'h02, 32'h0000_0000, 1'b1);
    rec(1'b1, 16'h0023, 8'h02, 32'h0000_0000, 1'b1);
    rec(1'b1, 16'h0024, 8'h02, 32'h0000_0000, 1'b1);
    rec(1'b1, 16'h0023, 8'h02, 32'h0000_0700, 1'b0);
    rec(1'b0, 16'h0023, 8'h02, 32'h0000_0000, 1'b0);
    // A second request while the first is still waiting must be ignored
    lat = 4'h6;
    rec(1'b0, 16'h0102, 8'h04, 32'h0000_0000, 1'b0);
    @(negedge sys_clk);
    rec_req = 1'b1;
    @(negedge sys_clk);
    rec_req = 1'b0;
    @(negedge sys_clk);
    rec_req = 1'b1;
    @(negedge sys_clk);
    rec_req = 1'b0;
    n = 0;
    repeat (20) begin
      @(negedge sys_clk);
      if (rec_done === 1'b1) n++;
    end
    chk("rec_done_count", n, 1);
    // Alarm codes at both ends of the range and just outside it
    foreach (acodes[i]) begin
      @(negedge sys_clk);
      alarm_code = acodes[i];
      alarm_valid = 1'b1;
      v = 1'b0;
      dc = 16'h0000;
      repeat (3) begin
        @(negedge sys_clk);
        alarm_valid = 1'b0;
        if (diag_valid === 1'b1) v = 1'b1;
        if (diag_valid === 1'b1) dc = diag_code;
      end
      ok = (acodes[i] != 8'h00) && (acodes[i] <= ALARM_MAX);
      chk("diag_valid", v, ok);
      if (ok) chk("diag_code", dc, {8'h00, acodes[i]} + DIAG_OFFSET);
    end
    // Reset in mid-run clears the state at once
    @(negedge sys_clk);
    resetn = 1'b0;
    @(negedge sys_clk);
    chk("reset_oper", state_oper, 1'b0);
    chk("reset_preop", state_preop, 1'b0);
    chk("reset_fault", bus_fault, 1'b0);
    chk("reset_saved", saved_words, 6'h00);
    resetn = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk("release_idle", state_oper | state_preop, 1'b0);
    results();
  end
endmodule
`default_nettype wire
